/* design/dmsep_port.sv */
// serial access front end of a 256 byte eeprom: two-wire or spi slave
// assumes all serial pins are asynchronous to mclk_in and much slower than it
`timescale 1ns/1ps
`default_nettype none

module dmsep_port #(
    parameter logic [4:0] CHIP_FIXED_BITS = dmsep_pkg::CHIP_FIXED_DEFAULT,
    parameter int MAX_PROG_BYTES = dmsep_pkg::MAX_PROG_BYTES,
    parameter int FIFO_DEPTH = dmsep_pkg::FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic mode_in,
    input wire logic chip_sel_bit_low_in,
    input wire logic chip_sel_bit_high_in,
    input wire logic serial_clock_in,
    input wire logic slave_select_n_in,
    input wire logic serial_in_in,
    output logic sda_data_out,
    output logic sda_oe_out,
    output logic serial_out_out,
    output logic serial_out_oe_out,
    output logic prog_inhibit_out,
    output logic vpp_on_out,
    output logic [7:0] byte_addr_out
);
    localparam int WORD_W = dmsep_pkg::ADDR_W + dmsep_pkg::DATA_W;

    initial begin
        if (MAX_PROG_BYTES < 1 || MAX_PROG_BYTES > 15 || FIFO_DEPTH < MAX_PROG_BYTES) begin
            $error("program burst must be 1..15 and fit in the fifo");
        end
    end

    logic [dmsep_pkg::SYNC_W-1:0] sync1;
    logic [dmsep_pkg::SYNC_W-1:0] sync2;
    logic sck_d;
    logic ss_d;
    logic sdi_d;
    logic mode;
    logic cs_high;
    logic cs_low;
    logic sck;
    logic ss_n;
    logic sdi;
    logic sck_rise;
    logic sck_fall;
    logic tw_start;
    logic tw_stop;
    logic ss_fall;
    logic ss_rise;

    dmsep_pkg::dmsep_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] byte_addr;
    logic ack_ok;
    logic is_read;
    logic inhibit;
    logic vpp_en;
    logic wrote;
    logic commit_req;
    logic [3:0] wcount;
    logic push;
    logic [WORD_W-1:0] push_word;
    logic [7:0] nbyte;
    logic room;

    logic commit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_word;
    logic drain;
    logic prog_we;
    logic [7:0] prog_addr;
    logic [7:0] prog_data;

    // eeprom cells are not cleared by reset
    logic [7:0] mem [dmsep_pkg::MEM_BYTES];

    function automatic logic is_protected(input logic [7:0] addr, input logic [1:0] code);
        logic [7:0] low_bound;
        low_bound = 8'h00 - (dmsep_pkg::PROT_STEP * {6'h00, code});
        is_protected = (code != 2'h0) && (addr >= low_bound) && (addr <= dmsep_pkg::PROT_TOP);
    endfunction : is_protected

    // two flops on every pin; select_n resets low so a pin already low is no falling edge
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= dmsep_pkg::SYNC_RST;
            sync2 <= dmsep_pkg::SYNC_RST;
            sck_d <= 1'h0;
            ss_d <= 1'h0;
            sdi_d <= 1'h1;
        end else begin
            sync1 <= {mode_in, chip_sel_bit_high_in, chip_sel_bit_low_in,
                      serial_clock_in, slave_select_n_in, serial_in_in};
            sync2 <= sync1;
            sck_d <= sck;
            ss_d <= ss_n;
            sdi_d <= sdi;
        end
    end

    assign mode = sync2[5];
    assign cs_high = sync2[4];
    assign cs_low = sync2[3];
    assign sck = sync2[2];
    assign ss_n = sync2[1];
    assign sdi = sync2[0];

    assign sck_rise = sck && !sck_d;
    assign sck_fall = !sck && sck_d;
    // start and stop: data moves while clock stays high
    assign tw_start = !mode && sck && sck_d && sdi_d && !sdi;
    assign tw_stop = !mode && sck && sck_d && !sdi_d && sdi;
    assign ss_fall = mode && ss_d && !ss_n;
    assign ss_rise = mode && !ss_d && ss_n;

    assign nbyte = {shreg[6:0], sdi};
    assign room = fifo_in_ready && (wcount < 4'(MAX_PROG_BYTES));

    // serial engine: bits are taken only on rising clock edges
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase <= dmsep_pkg::PH_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            byte_addr <= dmsep_pkg::ADDR_RST;
            ack_ok <= 1'h0;
            is_read <= 1'h0;
            inhibit <= 1'h1;
            vpp_en <= 1'h0;
            wrote <= 1'h0;
            commit_req <= 1'h0;
            wcount <= 4'h0;
            push <= 1'h0;
            push_word <= '0;
        end else begin
            push <= 1'h0;
            commit_req <= 1'h0;
            if (!mode) begin
                if (tw_start || tw_stop) begin
                    phase <= tw_start ? dmsep_pkg::PH_CMD : dmsep_pkg::PH_IDLE;
                    bitcnt <= 4'h0;
                    wcount <= 4'h0;
                    commit_req <= wrote;
                    wrote <= 1'h0;
                end else if (sck_rise && phase != dmsep_pkg::PH_IDLE) begin
                    if (bitcnt != dmsep_pkg::BIT_ACK) begin
                        shreg <= nbyte;
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == dmsep_pkg::BIT_LAST) begin
                            case (phase)
                                dmsep_pkg::PH_CMD:
                                    ack_ok <= (nbyte[7:3] == CHIP_FIXED_BITS) &&
                                              (nbyte[2:1] == {cs_high, cs_low});
                                dmsep_pkg::PH_ADDR: ack_ok <= 1'h1;
                                dmsep_pkg::PH_WR: ack_ok <= room;
                                default: ack_ok <= 1'h0;
                            endcase
                        end
                    end else begin
                        // acknowledge slot ends a byte
                        bitcnt <= 4'h0;
                        case (phase)
                            dmsep_pkg::PH_CMD: begin
                                if (!ack_ok) begin
                                    phase <= dmsep_pkg::PH_IDLE;
                                end else if (shreg[0]) begin
                                    phase <= dmsep_pkg::PH_RD;
                                    tx <= mem[byte_addr];
                                    byte_addr <= byte_addr + 8'h01;
                                    inhibit <= 1'h0;
                                end else begin
                                    phase <= dmsep_pkg::PH_ADDR;
                                end
                            end
                            dmsep_pkg::PH_ADDR: begin
                                byte_addr <= shreg;
                                phase <= dmsep_pkg::PH_WR;
                            end
                            dmsep_pkg::PH_WR: begin
                                if (ack_ok) begin
                                    push <= 1'h1;
                                    push_word <= {byte_addr, shreg};
                                    byte_addr <= byte_addr + 8'h01;
                                    wcount <= wcount + 4'h1;
                                    wrote <= 1'h1;
                                end
                            end
                            dmsep_pkg::PH_RD: begin
                                // no master acknowledge ends the read
                                if (sdi) begin
                                    phase <= dmsep_pkg::PH_IDLE;
                                end else begin
                                    tx <= mem[byte_addr];
                                    byte_addr <= byte_addr + 8'h01;
                                end
                            end
                            default: phase <= dmsep_pkg::PH_IDLE;
                        endcase
                    end
                end else if (sck_fall && phase == dmsep_pkg::PH_RD &&
                             bitcnt != dmsep_pkg::BIT_ACK) begin
                    tx <= {tx[6:0], 1'h0};
                end
            end else begin
                if (ss_fall) begin
                    phase <= dmsep_pkg::PH_CMD;
                    bitcnt <= 4'h0;
                    wcount <= 4'h0;
                    is_read <= 1'h0;
                end else if (ss_rise) begin
                    phase <= dmsep_pkg::PH_IDLE;
                    commit_req <= wrote;
                    wrote <= 1'h0;
                end else if (!ss_n && sck_rise && phase != dmsep_pkg::PH_IDLE) begin
                    shreg <= nbyte;
                    if (bitcnt != dmsep_pkg::BIT_LAST) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else begin
                        bitcnt <= 4'h0;
                        case (phase)
                            dmsep_pkg::PH_CMD: begin
                                case (nbyte)
                                    dmsep_pkg::OP_READ: begin
                                        is_read <= 1'h1;
                                        inhibit <= 1'h0;
                                        phase <= dmsep_pkg::PH_ADDR;
                                    end
                                    dmsep_pkg::OP_WRITE: begin
                                        is_read <= 1'h0;
                                        phase <= dmsep_pkg::PH_ADDR;
                                    end
                                    dmsep_pkg::OP_VPP_EN: vpp_en <= 1'h1;
                                    dmsep_pkg::OP_VPP_DIS: vpp_en <= 1'h0;
                                    // unknown opcode: ignore the rest of the frame
                                    default: phase <= dmsep_pkg::PH_IDLE;
                                endcase
                            end
                            dmsep_pkg::PH_ADDR: begin
                                if (is_read) begin
                                    phase <= dmsep_pkg::PH_RD;
                                    tx <= mem[nbyte];
                                    byte_addr <= nbyte + 8'h01;
                                end else begin
                                    phase <= dmsep_pkg::PH_WR;
                                    byte_addr <= nbyte;
                                end
                            end
                            dmsep_pkg::PH_WR: begin
                                // bytes beyond the burst or a full fifo are dropped
                                if (room) begin
                                    push <= 1'h1;
                                    push_word <= {byte_addr, nbyte};
                                    wcount <= wcount + 4'h1;
                                    wrote <= 1'h1;
                                end
                                byte_addr <= byte_addr + 8'h01;
                            end
                            dmsep_pkg::PH_RD: begin
                                tx <= mem[byte_addr];
                                byte_addr <= byte_addr + 8'h01;
                            end
                            default: phase <= dmsep_pkg::PH_IDLE;
                        endcase
                    end
                end else if (!ss_n && sck_fall && phase == dmsep_pkg::PH_RD) begin
                    tx <= {tx[6:0], 1'h0};
                end
            end
        end
    end

    // pin data changes only on falling clock edges; enables also switch with select, start, stop and idle
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sda_data_out <= 1'h0;
            sda_oe_out <= 1'h0;
            serial_out_out <= 1'h0;
            serial_out_oe_out <= 1'h0;
        end else if (!mode) begin
            serial_out_oe_out <= 1'h0;
            if (tw_start || tw_stop || phase == dmsep_pkg::PH_IDLE) begin
                sda_oe_out <= 1'h0;
            end else if (sck_fall) begin
                if (bitcnt == dmsep_pkg::BIT_ACK) begin
                    sda_oe_out <= ack_ok;
                end else if (phase == dmsep_pkg::PH_RD) begin
                    sda_oe_out <= ~tx[7];
                end else begin
                    sda_oe_out <= 1'h0;
                end
            end
        end else begin
            sda_oe_out <= 1'h0;
            if (ss_n) begin
                serial_out_oe_out <= 1'h0;
            end else begin
                // stays off until the first select falling edge after reset
                serial_out_oe_out <= (phase != dmsep_pkg::PH_IDLE);
                if (sck_fall && phase == dmsep_pkg::PH_RD) begin
                    serial_out_out <= tx[7];
                end
            end
        end
    end

    // queued bytes are programmed only once the command has ended
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            commit <= 1'h0;
            vpp_on_out <= 1'h0;
        end else begin
            if (commit_req) begin
                commit <= 1'h1;
            end else if (commit && !fifo_out_valid) begin
                commit <= 1'h0;
            end
            // two-wire runs the generator by itself; spi follows its enable
            vpp_on_out <= mode ? vpp_en : commit;
        end
    end

    assign drain = commit && fifo_out_valid;
    assign prog_addr = fifo_out_word[WORD_W-1:dmsep_pkg::DATA_W];
    assign prog_data = fifo_out_word[dmsep_pkg::DATA_W-1:0];
    assign prog_we = drain && !inhibit && (!mode || vpp_en) &&
        !is_protected(prog_addr, mem[dmsep_pkg::PROT_ADDR][dmsep_pkg::PROT_LSB +: 2]);

    // no erase needed: a programmed byte simply takes the new value
    always_ff @(posedge mclk_in) begin
        if (prog_we) begin
            mem[prog_addr] <= prog_data;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prog_inhibit_out <= 1'h1;
            byte_addr_out <= dmsep_pkg::ADDR_RST;
        end else begin
            prog_inhibit_out <= inhibit;
            byte_addr_out <= byte_addr;
        end
    end

    // fifo lets a burst queue while the command is still arriving
    dmsep_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(push_word),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(commit),
        .out_data_out(fifo_out_word)
    );
endmodule : dmsep_port

`default_nettype wire

/* design/dmsep_pkg_fifo.sv */
// package of shared constants for the dual mode serial eeprom port, and its write fifo
// assumes one clock domain for the fifo; fifo is compiled before the port module
`timescale 1ns/1ps
`default_nettype none

package dmsep_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 256;
    localparam int FIFO_DEPTH = 16;
    localparam int MAX_PROG_BYTES = 4;
    // fixed upper chip address bits: arbitrary value
    localparam logic [4:0] CHIP_FIXED_DEFAULT = 5'h14;
    // spi opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_VPP_EN = 8'h06;
    localparam logic [7:0] OP_VPP_DIS = 8'h04;
    // write protect control byte and its field
    localparam logic [7:0] PROT_ADDR = 8'hff;
    localparam int PROT_LSB = 2;
    localparam logic [7:0] PROT_TOP = 8'hfb;
    localparam logic [7:0] PROT_STEP = 8'h40;
    // reset address and bit counter limits
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // sync vector order: mode, cs high, cs low, clock, select_n, data in
    localparam int SYNC_W = 6;
    localparam logic [5:0] SYNC_RST = 6'h00;
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_CMD = 5'h02,
        PH_ADDR = 5'h04,
        PH_WR = 5'h08,
        PH_RD = 5'h10
    } dmsep_phase_t;
endpackage : dmsep_pkg

module dmsep_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("fifo depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic do_push;
    logic do_pop;

    assign in_ready_out = (count != (PW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = store[rd_ptr];
    assign do_push = in_valid_in && in_ready_out;
    assign do_pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            store[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            case ({do_push, do_pop})
                2'h2: count <= count + 1'b1;
                2'h1: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule : dmsep_fifo

`default_nettype wire

/* sim/dmsep_port_asserts.sv */
// checker for the serial eeprom port, bound to dmsep_port
// assumes serial pins change slowly, at least 4 mclk per phase
`timescale 1ns/1ps
`default_nettype none
module dmsep_port_asserts (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic mode_in,
    input wire logic chip_sel_bit_low_in,
    input wire logic chip_sel_bit_high_in,
    input wire logic serial_clock_in,
    input wire logic slave_select_n_in,
    input wire logic serial_in_in,
    input wire logic sda_data_out,
    input wire logic sda_oe_out,
    input wire logic serial_out_out,
    input wire logic serial_out_oe_out,
    input wire logic prog_inhibit_out,
    input wire logic vpp_on_out,
    input wire logic [7:0] byte_addr_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // six cycles covers the three-cycle pin delay plus margin
    spi_float_a: assert property ((mode_in && slave_select_n_in) [*6] |-> !serial_out_oe_out)
        else $error("spi output enabled while deselected");
    tw_no_spi_a: assert property ((!mode_in) [*6] |-> !serial_out_oe_out)
        else $error("spi output enabled in two-wire mode");
    open_drain_a: assert property (sda_oe_out |-> !sda_data_out)
        else $error("two-wire line driven high");
    spi_no_sda_a: assert property (mode_in [*6] |-> !sda_oe_out)
        else $error("two-wire line pulled in spi mode");
    so_on_fall_a: assert property ($changed(serial_out_out) && $past(serial_out_oe_out)
        |-> !$past(serial_clock_in, 2)) else $error("spi output moved while clock high");
    sda_on_fall_a: assert property (!mode_in && $changed(sda_oe_out)
        |-> !$past(serial_clock_in, 2)) else $error("two-wire line moved while clock high");
    reset_state_a: assert property ($rose(arst_n_in) |-> prog_inhibit_out && !vpp_on_out
        && byte_addr_out == 8'h00 && !sda_oe_out && !serial_out_oe_out)
        else $error("wrong state after reset");
    so_needs_sel_a: assert property ($rose(serial_out_oe_out)
        |-> mode_in && !$past(slave_select_n_in, 2)) else $error("spi output on unselected");
    cover property ($rose(serial_out_oe_out));
    cover property ($rose(sda_oe_out));
    cover property ($rose(vpp_on_out));
endmodule : dmsep_port_asserts
bind dmsep_port dmsep_port_asserts u_asserts (.mclk_in, .arst_n_in, .mode_in,
    .chip_sel_bit_low_in, .chip_sel_bit_high_in, .serial_clock_in, .slave_select_n_in,
    .serial_in_in, .sda_data_out, .sda_oe_out, .serial_out_out, .serial_out_oe_out,
    .prog_inhibit_out, .vpp_on_out, .byte_addr_out);
`default_nettype wire

/* sim/dmsep_master.sv */
// bus master model for the serial eeprom port: two-wire and spi
// assumes the bench ties its pins to the port; 160 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module dmsep_master (
    input wire logic mode_in,
    input wire logic sda_data_in,
    input wire logic sda_oe_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sclk_out,
    output logic sel_n_out,
    output logic din_out
);
    logic pull = 1'b0;
    logic mosi = 1'b0;
    logic last = 1'b0;
    logic [7:0] res;
    logic dummy;
    event got;
    initial begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
    end
    // pulled-up line: low while either party pulls
    assign din_out = mode_in ? mosi : !(pull || (sda_oe_in && !sda_data_in));
    task automatic spi_sel(input logic v);
        #80 sel_n_out = v;
    endtask : spi_sel
    task automatic spi_byte(input logic [7:0] tx, input bit chk);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #80 sclk_out = 1'b1;
            last = so_oe_in ? so_in : !last; // floating line never holds its value
            res[i] = last;
            #80 sclk_out = 1'b0;
        end
        if (chk) ->got;
    endtask : spi_byte
    // data moves 20 ns into the low phase so it never meets a clock edge
    task automatic tw_bit(input logic b, output logic r);
        #20 pull = !b;
        #60 sclk_out = 1'b1;
        r = din_out;
        #80 sclk_out = 1'b0;
    endtask : tw_bit
    task automatic tw_start();
        #20 pull = 1'b0;
        #60 sclk_out = 1'b1;
        #80 pull = 1'b1;
        #80 sclk_out = 1'b0;
    endtask : tw_start
    task automatic tw_stop();
        #20 pull = 1'b1;
        #60 sclk_out = 1'b1;
        #80 pull = 1'b0;
        #80;
    endtask : tw_stop
    task automatic tw_byte(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) tw_bit(tx[i], dummy);
        tw_bit(1'b1, dummy);
        res = {7'h00, dummy};
        ->got;
    endtask : tw_byte
    task automatic tw_read(input bit more);
        for (int i = 7; i >= 0; i--) tw_bit(1'b1, res[i]);
        ->got;
        tw_bit(!more, dummy);
    endtask : tw_read
endmodule : dmsep_master
`default_nettype wire

/* sim/dmsep_port_tb.sv */
// self-checking bench for dmsep_port: spi traffic, then two-wire traffic
// assumes dmsep_master stands in for the serial bus master
`timescale 1ns/1ps
`default_nettype none
module dmsep_port_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic mode = 1'b1;
    logic cs_lo = 1'b0;
    logic cs_hi = 1'b0;
    logic sclk, sel_n, din, sda_d, sda_oe, so, so_oe, inhibit, vpp_on;
    logic vpp_seen = 1'b0;
    logic [7:0] addr;
    logic [7:0] lo;
    logic [6:0] chip;
    logic [7:0] exp_mem [256];
    logic [7:0] exp_q [$];
    int fail_count = 0;
    int total_checks = 0;
    bit vpp = 1'b0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    dmsep_port dut (.mclk_in(mclk), .arst_n_in(arst_n), .mode_in(mode),
        .chip_sel_bit_low_in(cs_lo), .chip_sel_bit_high_in(cs_hi), .serial_clock_in(sclk),
        .slave_select_n_in(sel_n), .serial_in_in(din), .sda_data_out(sda_d),
        .sda_oe_out(sda_oe), .serial_out_out(so), .serial_out_oe_out(so_oe),
        .prog_inhibit_out(inhibit), .vpp_on_out(vpp_on), .byte_addr_out(addr));
    dmsep_master u_m (.mode_in(mode), .sda_data_in(sda_d), .sda_oe_in(sda_oe), .so_in(so),
        .so_oe_in(so_oe), .sclk_out(sclk), .sel_n_out(sel_n), .din_out(din));
    always @(posedge mclk) if (vpp_on) vpp_seen <= 1'b1;
    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check_port(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            fail_count++;
            $display("ERROR %0t port value %h, expected %h", $time, got, want);
        end
    endtask : check_port
    task automatic check_byte(input logic [7:0] got);
        total_checks++;
        if (exp_q.size() == 0 || got !== exp_q[0]) begin
            fail_count++;
            $display("ERROR %0t serial result %h unexpected", $time, got);
        end
        if (exp_q.size() != 0) exp_q.delete(0);
    endtask : check_byte
    always @(u_m.got) check_byte(u_m.res);
    function automatic bit prot(input logic [7:0] a);
        return a <= 8'hfb && {1'b0, a} >= 9'h100 - 9'(exp_mem[255][3:2]) * 9'h040;
    endfunction : prot
    // note a data byte as the port should keep it: four at most, none protected
    task automatic note(input logic [7:0] a, input int i, input logic [7:0] d);
        if (i < 4 && !prot(a)) exp_mem[a] = d;
    endtask : note
    task automatic spi_cmd(input logic [7:0] op);
        u_m.spi_sel(1'b0);
        u_m.spi_byte(op, 1'b0);
        u_m.spi_sel(1'b1);
    endtask : spi_cmd
    task automatic spi_write(input logic [7:0] a, input int n, input logic [39:0] dv);
        u_m.spi_sel(1'b0);
        u_m.spi_byte(dmsep_pkg::OP_WRITE, 1'b0);
        u_m.spi_byte(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            if (vpp) note(a + 8'(i), i, dv[39 - 8 * i -: 8]);
            u_m.spi_byte(dv[39 - 8 * i -: 8], 1'b0);
        end
        u_m.spi_sel(1'b1);
        repeat (20) @(negedge mclk);
    endtask : spi_write
    task automatic spi_read(input logic [7:0] a, input int n, input bit chk);
        u_m.spi_sel(1'b0);
        u_m.spi_byte(dmsep_pkg::OP_READ, 1'b0);
        u_m.spi_byte(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            if (chk) exp_q.push_back(exp_mem[a + 8'(i)]);
            u_m.spi_byte(8'h00, chk);
        end
        u_m.spi_sel(1'b1);
    endtask : spi_read
    task automatic tw_head(input logic [7:0] a);
        {cs_hi, cs_lo} = 2'($urandom());
        chip = {dmsep_pkg::CHIP_FIXED_DEFAULT, cs_hi, cs_lo};
        u_m.tw_start();
        exp_q.push_back(8'h00);
        u_m.tw_byte({chip, 1'b0});
        exp_q.push_back(8'h00);
        u_m.tw_byte(a);
    endtask : tw_head
    task automatic tw_write(input logic [7:0] a, input int n, input logic [39:0] dv);
        int k;
        tw_head(a);
        for (int i = 0; i < n; i++) begin
            note(a + 8'(i), i, dv[39 - 8 * i -: 8]);
            exp_q.push_back(i < 4 ? 8'h00 : 8'h01);
            u_m.tw_byte(dv[39 - 8 * i -: 8]);
        end
        if (n <= 4) check_port(addr, a + 8'(n));
        vpp_seen = 1'b0;
        u_m.tw_stop();
        for (k = 0; k < 40 && !vpp_seen; k++) @(negedge mclk);
        check_port({7'h00, vpp_seen}, 8'h01);
    endtask : tw_write
    task automatic tw_read(input logic [7:0] a, input int n);
        tw_head(a);
        u_m.tw_start();
        exp_q.push_back(8'h00);
        u_m.tw_byte({chip, 1'b1});
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(exp_mem[a + 8'(i)]);
            u_m.tw_read(i < n - 1);
        end
        u_m.tw_stop();
    endtask : tw_read
    initial begin
        #900us;
        fail_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(29737));
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        check_port({5'h00, inhibit, vpp_on, so_oe}, 8'h04);
        check_port(addr, dmsep_pkg::ADDR_RST);
        repeat (6) @(negedge mclk);
        spi_read(8'h00, 1, 1'b0);
        check_port({7'h00, inhibit}, 8'h00);
        spi_cmd(dmsep_pkg::OP_VPP_EN);
        vpp = 1'b1;
        check_port({7'h00, vpp_on}, 8'h01);
        spi_write(8'hff, 1, 40'h00_0000_0000);
        spi_write(8'h34, 1, {$urandom(), 8'h00});
        spi_write(8'h30, 5, {$urandom(), 8'($urandom())});
        spi_read(8'h30, 5, 1'b1);
        for (int p = 1; p < 4; p++) begin
            lo = 8'(9'h100 - 9'(p) * 9'h040);
            spi_write(8'hff, 1, 40'h00_0000_0000);
            spi_write(lo, 1, {$urandom(), 8'h00});
            spi_write(8'hff, 1, {4'h0, 2'(p), 34'h0_0000_0000});
            spi_write(lo - 8'h01, 2, {$urandom(), 8'h00});
            spi_read(lo - 8'h01, 2, 1'b1);
        end
        spi_write(8'hff, 1, 40'h00_0000_0000);
        spi_cmd(dmsep_pkg::OP_VPP_DIS);
        vpp = 1'b0;
        check_port({7'h00, vpp_on}, 8'h00);
        spi_write(8'h30, 1, {$urandom(), 8'h00});
        spi_read(8'h30, 1, 1'b1);
        mode = 1'b0;
        repeat (10) @(negedge mclk);
        tw_write(8'h50, 2, {$urandom(), 8'h00});
        tw_write(8'h64, 1, {$urandom(), 8'h00});
        tw_write(8'h60, 5, {$urandom(), 8'($urandom())});
        tw_read(8'h50, 2);
        tw_read(8'h60, 5);
        u_m.tw_start();
        exp_q.push_back(8'h01);
        u_m.tw_byte({chip ^ 7'h01, 1'b0});
        u_m.tw_stop();
        print_verdict();
    end
endmodule : dmsep_port_tb
`default_nettype wire
